// >>> cbc_pkg.sv
// Purpose: shared constants for the bridge control and interrupt pin registers
// Assumes: byte addresses of configuration space, two functions, one per socket
// Notes: all offsets, bit positions and reset values live here
package cbc_pkg;

  // ****************************************
  // configuration addresses
  // ****************************************
  localparam logic [7:0] OFF_INTPIN = 8'h3D;
  localparam logic [7:0] OFF_BCTL = 8'h3E;
  localparam logic [5:0] DW_INTPIN_BCTL = 6'h0F;
  localparam int BE_INTPIN = 1;
  localparam int BE_BCTL_LO = 2;
  localparam int BE_BCTL_HI = 3;

  // ****************************************
  // bridge control fields
  // ****************************************
  localparam int B_CARD_PARITY_RESPONSE_ENABLE = 0;
  localparam int B_CARD_SYSERR_FORWARD_ENABLE = 1;
  localparam int B_ISA_RANGE_FILTER_ENABLE = 2;
  localparam int B_VGA_FORWARD_ENABLE = 3;
  localparam int B_MABT = 5;
  localparam int B_CRST = 6;
  localparam int B_IRQSEL = 7;
  localparam int B_PF0 = 8;
  localparam int B_PF1 = 9;
  localparam int B_POST = 10;
  localparam logic [15:0] BCTL_RESET = 16'h0340;
  // writable bits kept per socket; bit 5 is shared and held apart
  localparam logic [15:0] BCTL_SOCK_MASK = 16'h07CF;
  localparam logic [15:0] BCTL_SHARED_MASK = 16'h0020;

  // ****************************************
  // interrupt pin values
  // ****************************************
  localparam logic [7:0] INTPIN_A = 8'h01;
  localparam logic [7:0] INTPIN_B = 8'h02;
  localparam logic [7:0] CFG_ZERO = 8'h00;

endpackage : cbc_pkg

// >>> cbc_sock_ctrl.sv
// Purpose: per-socket storage of the socket-dependent bridge control bits
// Assumes: write strobes already qualified by function and byte enable
// Notes: card reset bit keeps power-management context
`timescale 1ns/1ps
module cbc_sock_ctrl
  import cbc_pkg::*;
(
  // clock and resets
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic pci_bus_reset_in_n,
  input wire logic pme_enable,
  // write side
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [15:0] wdata,
  // stored bits, reserved and shared positions read zero
  output logic [15:0] ctl
);

  logic [15:0] next_ctl;

  always_comb
  begin
    next_ctl = ctl;
    if (wr_lo)
    begin
      next_ctl[7:0] = wdata[7:0] & BCTL_SOCK_MASK[7:0];
    end
    if (wr_hi)
    begin
      next_ctl[15:8] = wdata[15:8] & BCTL_SOCK_MASK[15:8];
    end
  end

  // ****************************************
  // ordinary bits: loaded with the reset value by either reset
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!nrst || !pci_bus_reset_in_n)
    begin
      ctl[15:7] <= BCTL_RESET[15:7];
      ctl[5:0] <= BCTL_RESET[5:0];
    end
    else
    begin
      ctl[15:7] <= next_ctl[15:7];
      ctl[5:0] <= next_ctl[5:0];
    end
  end

  // ****************************************
  // card reset bit: context kept over bus reset while pme is on
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!nrst || (!pci_bus_reset_in_n && !pme_enable))
    begin
      ctl[B_CRST] <= BCTL_RESET[B_CRST];
    end
    else if (pci_bus_reset_in_n)
    begin
      ctl[B_CRST] <= next_ctl[B_CRST];
    end
  end

endmodule : cbc_sock_ctrl

// >>> cbc_cfg_regs.sv
// Purpose: interrupt pin and bridge control registers of a two-socket bridge
// Assumes: configuration accesses arrive synchronous to core_clk, one per cycle
// Notes: read data returns one cycle after the read strobe
// Function
// - interrupt pin reads 01h in function 0, 02h in function 1, tie clear
// - with tie set, second interrupt joins first and both pins read 01h
// - bridge control bits 15 to 11 and bit 4 read zero, ignore writes
// - bit 10 enables burst write posting, per socket, resets to 0
// - bit 9 makes memory window 1 prefetchable, per socket, resets to 1
// - bit 8 makes memory window 0 prefetchable, per socket, resets to 1
// - bit 7 routes card interrupts to PCI lines or legacy IRQ
// - bit 6 asserts card reset on its socket, resets to 1
// - PCI bus reset also passes through to card reset
// - card reset bit set back to 1 only by global reset while PME enabled
// - bit 5 reports CardBus master aborts as target abort and SERR
// - bit 5 is one shared element; software uses function 0
// - bit 3 enables forwarding of VGA addresses to the socket
// - bit 2 blocks last 768 bytes of each 1K ISA I/O block
// - bit 1 forwards card system error to PCI SERR, per socket
// - bit 0 enables parity error reporting on the card, per socket
// - bridge control resets to 0340h; interrupt pin never takes writes
`timescale 1ns/1ps
module cbc_cfg_regs
  import cbc_pkg::*;
#(
  parameter int NSOCK = 2
)
(
  // clock and resets
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic pci_bus_reset_in_n,
  input wire logic pme_enable,
  // system level settings
  input wire logic interrupt_tie,
  input wire logic serr_enable,
  // configuration access
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic cfg_func,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // card side events
  input wire logic [NSOCK-1:0] func_irq_in,
  input wire logic [NSOCK-1:0] card_syserr_in,
  input wire logic [NSOCK-1:0] card_parity_err_in,
  input wire logic [NSOCK-1:0] cb_master_abort_in,
  // card and pci side results
  output logic [NSOCK-1:0] card_reset_n,
  output logic [NSOCK-1:0] card_parity_report,
  output logic [NSOCK-1:0] legacy_irq_out,
  output logic pci_inta_out,
  output logic pci_intb_out,
  output logic pci_serr_out,
  output logic pci_target_abort_out,
  // control levels for the datapath
  output logic [NSOCK-1:0] write_post_enable,
  output logic [NSOCK-1:0] window0_prefetchable,
  output logic [NSOCK-1:0] window1_prefetchable,
  output logic [NSOCK-1:0] functional_irq_route_select,
  output logic [NSOCK-1:0] vga_forward_enable,
  output logic [NSOCK-1:0] isa_range_filter_enable,
  output logic [NSOCK-1:0] card_syserr_forward_enable,
  output logic [NSOCK-1:0] card_parity_response_enable,
  output logic master_abort_report_mode
);

  // ****************************************
  // decode
  // ****************************************
  function automatic logic [7:0] intpin_value(input logic func, input logic tie);
    intpin_value = (func && !tie) ? INTPIN_B : INTPIN_A;
  endfunction : intpin_value

  logic hit;
  logic [NSOCK-1:0] wr_lo;
  logic [NSOCK-1:0] wr_hi;
  logic [15:0] ctl [NSOCK];
  logic [15:0] rd_ctl;
  logic [NSOCK-1:0] to_pci;
  logic mabt_any;

  // accesses are refused while the pci bus is in reset
  assign hit = (cfg_addr[7:2] == DW_INTPIN_BCTL) && pci_bus_reset_in_n;
  assign rd_ctl = ctl[cfg_func] | (master_abort_report_mode ? BCTL_SHARED_MASK : 16'h0000);
  assign mabt_any = |(cb_master_abort_in) && master_abort_report_mode;

  // ****************************************
  // per-socket storage, one per function
  // ****************************************
  genvar s;
  generate
    for (s = 0; s < NSOCK; s++)
    begin : g_sock
      // interrupt pin byte enable has no write path at all
      assign wr_lo[s] = cfg_wr && hit && cfg_be[BE_BCTL_LO] && (cfg_func == s[0]);
      assign wr_hi[s] = cfg_wr && hit && cfg_be[BE_BCTL_HI] && (cfg_func == s[0]);

      cbc_sock_ctrl u_ctrl (
        .core_clk(core_clk),
        .nrst(nrst),
        .pci_bus_reset_in_n(pci_bus_reset_in_n),
        .pme_enable(pme_enable),
        .wr_lo(wr_lo[s]),
        .wr_hi(wr_hi[s]),
        .wdata(cfg_wdata[31:16]),
        .ctl(ctl[s])
      );

      assign write_post_enable[s] = ctl[s][B_POST];
      assign window1_prefetchable[s] = ctl[s][B_PF1];
      assign window0_prefetchable[s] = ctl[s][B_PF0];
      assign functional_irq_route_select[s] = ctl[s][B_IRQSEL];
      assign vga_forward_enable[s] = ctl[s][B_VGA_FORWARD_ENABLE];
      assign isa_range_filter_enable[s] = ctl[s][B_ISA_RANGE_FILTER_ENABLE];
      assign card_syserr_forward_enable[s] = ctl[s][B_CARD_SYSERR_FORWARD_ENABLE];
      assign card_parity_response_enable[s] = ctl[s][B_CARD_PARITY_RESPONSE_ENABLE];
      assign to_pci[s] = func_irq_in[s] && !ctl[s][B_IRQSEL];

      // ****************************************
      // card side outputs
      // ****************************************
      always_ff @(posedge core_clk)
      begin
        if (!nrst)
        begin
          card_reset_n[s] <= 1'b0;
          card_parity_report[s] <= 1'b0;
          legacy_irq_out[s] <= 1'b0;
        end
        else
        begin
          card_reset_n[s] <= !(ctl[s][B_CRST] || !pci_bus_reset_in_n);
          card_parity_report[s] <= card_parity_err_in[s] && ctl[s][B_CARD_PARITY_RESPONSE_ENABLE];
          legacy_irq_out[s] <= func_irq_in[s] && ctl[s][B_IRQSEL];
        end
      end
    end
  endgenerate

  // ****************************************
  // shared master abort mode bit
  // ****************************************
  // one flop for both sockets; a write through function 1 lands here too
  always_ff @(posedge core_clk)
  begin
    if (!nrst || !pci_bus_reset_in_n)
    begin
      master_abort_report_mode <= BCTL_RESET[B_MABT];
    end
    else if (|wr_lo)
    begin
      master_abort_report_mode <= cfg_wdata[16 + B_MABT];
    end
  end

  // ****************************************
  // pci side outputs
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      pci_inta_out <= 1'b0;
      pci_intb_out <= 1'b0;
    end
    else
    begin
      pci_inta_out <= to_pci[0] || (interrupt_tie && to_pci[1]);
      pci_intb_out <= to_pci[1] && !interrupt_tie;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      pci_serr_out <= 1'b0;
      pci_target_abort_out <= 1'b0;
    end
    else
    begin
      pci_serr_out <= serr_enable && (|(card_syserr_in & card_syserr_forward_enable)
                      || mabt_any);
      pci_target_abort_out <= mabt_any;
    end
  end

  // ****************************************
  // configuration read
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      cfg_rdata <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
    end
    else
    begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd && hit)
      begin
        cfg_rdata <= {rd_ctl, intpin_value(cfg_func, interrupt_tie), CFG_ZERO};
      end
      else
      begin
        cfg_rdata <= 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_intpin_f1_plain: assert property (@(posedge core_clk) disable iff (!nrst)
    cfg_rd && hit && cfg_func && !interrupt_tie |=> cfg_rdata[15:8] == 8'h02)
    else $error("function 1 interrupt pin not 02h");

  a_intpin_tied: assert property (@(posedge core_clk) disable iff (!nrst)
    cfg_rd && hit && interrupt_tie |=> cfg_rdata[15:8] == 8'h01)
    else $error("tied interrupt pin not 01h");

  a_reserved_bits_read_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    cfg_rvalid |-> cfg_rdata[31:27] == 5'h00 && !cfg_rdata[20])
    else $error("reserved bridge control bits not zero");

  a_bctl_reset_val: assert property (@(posedge core_clk)
    !nrst |=> rd_ctl == 16'h0340 || cfg_func)
    else $error("bridge control reset value wrong");

  a_crst_drives_pin: assert property (@(posedge core_clk) disable iff (!nrst)
    ctl[0][B_CRST] |=> !card_reset_n[0])
    else $error("card reset bit did not assert card reset");

  a_pci_bus_reset_in_pass_thru: assert property (@(posedge core_clk) disable iff (!nrst)
    !pci_bus_reset_in_n |=> card_reset_n == '0)
    else $error("bus reset not passed to card");

  a_crst_pme_kept: assert property (@(posedge core_clk) disable iff (!nrst)
    !pci_bus_reset_in_n && pme_enable |=> ctl[0][B_CRST] == $past(ctl[0][B_CRST]))
    else $error("card reset bit lost with pme enabled");

  a_crst_pme_off: assert property (@(posedge core_clk) disable iff (!nrst)
    !pci_bus_reset_in_n && !pme_enable |=> ctl[1][B_CRST])
    else $error("card reset bit not restored by bus reset");

  a_serr_forward: assert property (@(posedge core_clk) disable iff (!nrst)
    card_syserr_in[0] && ctl[0][B_CARD_SYSERR_FORWARD_ENABLE] && serr_enable ##1 nrst |-> pci_serr_out)
    else $error("card system error not forwarded");

  a_parity_ignored: assert property (@(posedge core_clk) disable iff (!nrst)
    !ctl[1][B_CARD_PARITY_RESPONSE_ENABLE] |=> !card_parity_report[1])
    else $error("parity reported while disabled");

  a_mabt_report: assert property (@(posedge core_clk) disable iff (!nrst)
    !master_abort_report_mode |=> !pci_target_abort_out)
    else $error("master abort reported while mode clear");

  a_legacy_route: assert property (@(posedge core_clk) disable iff (!nrst)
    func_irq_in[0] && ctl[0][B_IRQSEL] |=> legacy_irq_out[0])
    else $error("routed card interrupt missing on legacy line");

  a_pci_route_b: assert property (@(posedge core_clk) disable iff (!nrst)
    func_irq_in[1] && !ctl[1][B_IRQSEL] && !interrupt_tie |=> pci_intb_out)
    else $error("card interrupt not routed to second pci line");

  a_tie_joins_a: assert property (@(posedge core_clk) disable iff (!nrst)
    func_irq_in[1] && !ctl[1][B_IRQSEL] && interrupt_tie |=> pci_inta_out && !pci_intb_out)
    else $error("tied interrupt not joined to first line");

  a_mabt_shared: assert property (@(posedge core_clk) disable iff (!nrst)
    |wr_lo |=> master_abort_report_mode == $past(cfg_wdata[16 + B_MABT]))
    else $error("shared master abort bit not written");

  a_mabt_abort: assert property (@(posedge core_clk) disable iff (!nrst)
    master_abort_report_mode && |cb_master_abort_in |=> pci_target_abort_out)
    else $error("master abort not signalled as target abort");

  a_mabt_serr: assert property (@(posedge core_clk) disable iff (!nrst)
    master_abort_report_mode && |cb_master_abort_in && serr_enable |=> pci_serr_out)
    else $error("master abort did not raise system error");

  a_parity_report: assert property (@(posedge core_clk) disable iff (!nrst)
    card_parity_err_in[0] && ctl[0][B_CARD_PARITY_RESPONSE_ENABLE] |=> card_parity_report[0])
    else $error("enabled parity error not reported");

  a_serr_blocked: assert property (@(posedge core_clk) disable iff (!nrst)
    !serr_enable |=> !pci_serr_out)
    else $error("system error raised while reporting disabled");

  a_isa_write: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_lo[0] |=> isa_range_filter_enable[0] == $past(cfg_wdata[16 + B_ISA_RANGE_FILTER_ENABLE]))
    else $error("isa filter bit not written");

  a_post_write: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_hi[1] |=> write_post_enable[1] == $past(cfg_wdata[16 + B_POST]))
    else $error("write posting bit not written");

  a_reserved_bits_hi_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_hi[0] |=> ctl[0][15:11] == 5'h00)
    else $error("reserved bridge control bits took a write");

endmodule : cbc_cfg_regs

// >>> cbc_card_model.sv
// Purpose: card side of both sockets, presents event levels to the bridge
// Assumes: the bench sets the wanted levels just after a rising edge
// Notes: a card held in reset stays silent; master aborts come from the bus, not the card
`timescale 1ns/1ps
module cbc_card_model
(
  // clock and card reset
  input wire logic core_clk,
  input wire logic [1:0] card_reset_n,
  // wanted levels: abort, parity, syserr, irq, two sockets each
  input wire logic [7:0] want,
  // event lines toward the bridge
  output logic [1:0] irq,
  output logic [1:0] syserr,
  output logic [1:0] perr,
  output logic [1:0] mabt
);
  always_ff @(posedge core_clk)
  begin
    irq <= want[1:0] & card_reset_n;
    syserr <= want[3:2] & card_reset_n;
    perr <= want[5:4] & card_reset_n;
    mabt <= want[7:6];
  end
endmodule : cbc_card_model

// >>> cbc_cfg_regs_tb.sv
// Purpose: self-checking bench for bridge control and interrupt pin
// Assumes: one access at a time, inputs driven 1 ns after the edge
// Notes: a shadow copy of both sockets predicts reads and levels
`timescale 1ns/1ps
module cbc_cfg_regs_tb
  import cbc_pkg::*;
;
  localparam logic [7:0] A_DW = {DW_INTPIN_BCTL, 2'b00};
  logic core_clk, nrst, bus_rst_n, pme, tie, serr_en, cfg_rd, cfg_wr, cfg_func;
  logic cfg_rvalid, inta, intb, serr, tabt, mab_mode, mab;
  logic [7:0] cfg_addr, want;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, d, dw, r;
  logic [1:0] irq, syserr, perr, mabt, crst_n, cpar, lirq;
  logic [1:0] post, pf0, pf1, rsel, vga, isa, cse, cpe;
  logic [15:0] sh [2];
  int fails, num_checks, seed;

  cbc_cfg_regs #(.NSOCK(2)) cbc_cfg_regs_inst (
    .core_clk(core_clk), .nrst(nrst), .pci_bus_reset_in_n(bus_rst_n),
    .pme_enable(pme), .interrupt_tie(tie), .serr_enable(serr_en),
    .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_func(cfg_func), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .func_irq_in(irq), .card_syserr_in(syserr),
    .card_parity_err_in(perr), .cb_master_abort_in(mabt),
    .card_reset_n(crst_n), .card_parity_report(cpar), .legacy_irq_out(lirq),
    .pci_inta_out(inta), .pci_intb_out(intb), .pci_serr_out(serr),
    .pci_target_abort_out(tabt), .write_post_enable(post),
    .window0_prefetchable(pf0), .window1_prefetchable(pf1),
    .functional_irq_route_select(rsel), .vga_forward_enable(vga),
    .isa_range_filter_enable(isa), .card_syserr_forward_enable(cse),
    .card_parity_response_enable(cpe), .master_abort_report_mode(mab_mode)
  );

  cbc_card_model cbc_card_model_inst (
    .core_clk(core_clk), .card_reset_n(crst_n), .want(want),
    .irq(irq), .syserr(syserr), .perr(perr), .mabt(mabt)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ********
  // checking and bus tasks
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic wr(input logic f, input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] w);
    @(posedge core_clk);
    #1;
    cfg_wr = 1'b1;
    cfg_func = f;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = w;
    @(posedge core_clk);
    #1;
    cfg_wr = 1'b0;
    // shadow follows only decoded bytes; pin byte has no storage
    if (a[7:2] == DW_INTPIN_BCTL && be[BE_BCTL_LO])
      sh[f][7:0] = w[23:16];
    if (a[7:2] == DW_INTPIN_BCTL && be[BE_BCTL_HI])
      sh[f][15:8] = w[31:24];
    if (a[7:2] == DW_INTPIN_BCTL && be[BE_BCTL_LO] && !f)
      mab = w[21];
  endtask : wr

  task automatic rd(input logic f, input logic [7:0] a, output logic [31:0] rv);
    int n;
    @(posedge core_clk);
    #1;
    cfg_rd = 1'b1;
    cfg_func = f;
    cfg_addr = a;
    @(posedge core_clk);
    #1;
    cfg_rd = 1'b0;
    n = 0;
    while (cfg_rvalid !== 1'b1 && n < 4)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n == 4)
    begin
      fails++;
      end_sim();
    end
    else
      rv = cfg_rdata;
  endtask : rd

  function automatic logic [1:0] bits(input int b);
    return {sh[1][b], sh[0][b]};
  endfunction : bits

  // second socket joins the first line while the tie is set
  function automatic logic [7:0] eev();
    logic [1:0] p;
    logic ab;
    p = irq & ~bits(B_IRQSEL);
    ab = |mabt & mab;
    return {irq & bits(B_IRQSEL), perr & bits(B_CARD_PARITY_RESPONSE_ENABLE), p[0] | (tie & p[1]),
      p[1] & ~tie, ab, serr_en & ((|(syserr & bits(B_CARD_SYSERR_FORWARD_ENABLE))) | ab)};
  endfunction : eev

  task automatic check_regs();
    logic [8:0] lv;
    logic [15:0] eb;
    for (int f = 0; f < 2; f++)
    begin
      eb = (sh[f] & BCTL_SOCK_MASK) | {10'h000, mab, 5'h00};
      rd(f[0], A_DW, d);
      check(d, {eb, (f[0] && !tie) ? INTPIN_B : INTPIN_A, CFG_ZERO});
      lv = {post[f], pf1[f], pf0[f], rsel[f], vga[f], isa[f], cse[f], cpe[f], mab_mode};
      check(lv, {sh[f][10:7], sh[f][3:0], mab});
      check(crst_n[f], !sh[f][B_CRST]);
    end
  endtask : check_regs

  // ********
  // main sequence
  // ********
  initial
  begin
    seed = 7623;
    fails = 0;
    num_checks = 0;
    {nrst, bus_rst_n, pme, tie, serr_en, cfg_rd, cfg_wr, cfg_func} = 8'h40;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
    want = 8'h00;
    sh[0] = BCTL_RESET;
    sh[1] = BCTL_RESET;
    mab = 1'b0;
    repeat (12) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    check_regs();
    rd(1'b0, 8'h40, d);
    check(d, 32'h0);
    wr(1'b0, A_DW, 4'hF, 32'hFFFFFFFF);
    check_regs();
    for (int i = 0; i < 60; i++)
    begin
      r = $random(seed);
      dw = $random(seed);
      if (r[0])
        dw[21] = mab;
      wr(r[0], (r[3:1] == 3'h0) ? 8'h44 : A_DW, r[7:4], dw);
      check_regs();
      @(posedge core_clk);
      #1;
      want = r[15:8];
      tie = r[16];
      serr_en = r[17];
      repeat (3) @(posedge core_clk);
      #1;
      check({lirq, cpar, inta, intb, tabt, serr}, eev());
    end
    // card reset bit must survive a bus reset only while PME is enabled
    for (int p = 0; p < 2; p++)
    begin
      wr(1'b0, A_DW, 4'h4, 32'h0);
      wr(1'b1, A_DW, 4'hC, 32'hFFDF0000);
      @(posedge core_clk);
      #1;
      pme = p[0];
      bus_rst_n = 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      check(crst_n, 2'b00);
      bus_rst_n = 1'b1;
      for (int f = 0; f < 2; f++)
        sh[f] = BCTL_RESET & ~(16'h0040 & {16{p[0] & !sh[f][B_CRST]}});
      mab = 1'b0;
      repeat (2) @(posedge core_clk);
      check_regs();
    end
    end_sim();
  end
endmodule : cbc_cfg_regs_tb
